// ==== i2cms_cfg.svh ====
`ifndef I2CMS_CFG_SVH
`define I2CMS_CFG_SVH

// Link clock cycles per quarter of one bus bit
`define I2CMS_QTR_DIV 4
// Bit counter value of the first (most significant) bit of a byte
`define I2CMS_BIT_FIRST 3'h7
// Bit counter value of the last bit of a byte
`define I2CMS_BIT_LAST 3'h0
// Reset value of byte-wide data registers (the quarter counter qcnt resets to QMAX instead)
`define I2CMS_BYTE_RST 8'h00

`endif

// ==== i2cms_pkg.sv ====
`default_nettype none

package i2cms_pkg;

  typedef enum logic [2:0] {
    S_IDLE,
    S_START,
    S_BIT,
    S_ACK,
    S_HOLD,
    S_HALT,
    S_RESTART,
    S_STOP
  } i2cms_state_type;

  // Events from the link engine, each carried as a toggle
  typedef struct packed {
    logic consume;
    logic start_done;
    logic stop_done;
    logic ack;
    logic rx;
  } i2cms_evt_type;

  // Control levels handed to the link engine
  typedef struct packed {
    logic enable;
    logic start;
    logic stop;
    logic full;
    logic nak;
  } i2cms_ctl_type;

endpackage

`default_nettype wire

// ==== i2cms_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "i2cms_cfg.svh"

module i2cms_sequencer #(
  parameter int unsigned QTR_DIV = `I2CMS_QTR_DIV
) (
  // System clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // Free-running clock of the bus engine, 4 * QTR_DIV cycles per bus bit
  input  wire logic       link_clk,
  // Control bits
  input  wire logic       controller_enable,
  input  wire logic       tx_irq_enable,
  input  wire logic       nak_request,
  input  wire logic       start_set,
  input  wire logic       stop_set,
  input  wire logic       flush_set,
  // Data register access
  input  wire logic       data_wr,
  input  wire logic [7:0] data_wdata,
  input  wire logic       data_rd,
  output logic      [7:0] rx_data,
  // Status
  output logic            start_bit,
  output logic            stop_bit,
  output logic            tx_data_empty_flag,
  output logic            rx_data_full_flag,
  output logic            nack_irq_flag,
  output logic            ack_status,
  output logic            tx_irq,
  output logic            tx_dma_req,
  // Bus pins, open drain
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe
);

  localparam logic [7:0] QMAX = 8'(QTR_DIV - 1);

  // System domain state
  logic       tx_full;
  logic [7:0] tx_data;
  logic       rd_tgl;
  i2cms_pkg::i2cms_evt_type evt_meta;
  i2cms_pkg::i2cms_evt_type evt_sync;
  i2cms_pkg::i2cms_evt_type evt_seen;
  i2cms_pkg::i2cms_evt_type evt;

  // Link domain state
  logic       link_rst_meta;
  logic       link_rst;
  i2cms_pkg::i2cms_ctl_type ctl_src;
  i2cms_pkg::i2cms_ctl_type ctl_meta;
  i2cms_pkg::i2cms_ctl_type ctl_s;
  logic       rd_meta;
  logic       rd_sync;
  logic       rd_seen;
  logic       scl_meta;
  logic       scl_s;
  logic       sda_meta;
  logic       sda_s;
  logic [7:0] qcnt;
  logic       stretch;
  logic       tick;
  logic       stall;
  i2cms_pkg::i2cms_state_type state;
  logic [1:0] phase;
  logic [2:0] bitcnt;
  logic [7:0] shreg;
  logic       rd_mode;
  logic       addr_byte;
  logic       dir_rd;
  logic       ack_val;
  logic       ack_halt;
  logic [7:0] rx_byte;
  i2cms_pkg::i2cms_evt_type evt_tgl;

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

  // ---------------- System domain ----------------

  always_ff @(posedge clk) begin
    if (srst) begin
      evt_meta <= '0;
      evt_sync <= '0;
      evt_seen <= '0;
    end else begin
      evt_meta <= evt_tgl;
      evt_sync <= evt_meta;
      evt_seen <= evt_sync;
    end
  end

  assign evt = i2cms_pkg::i2cms_evt_type'(evt_sync ^ evt_seen);

  // Set by software wins over the hardware clear
  always_ff @(posedge clk) begin
    if (srst) begin
      start_bit <= 1'b0;
    end else if (start_set) begin
      start_bit <= 1'b1;
    end else if (evt.start_done) begin
      start_bit <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      stop_bit <= 1'b0;
    end else if (stop_set) begin
      stop_bit <= 1'b1;
    end else if (evt.stop_done) begin
      stop_bit <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_full <= 1'b0;
      tx_data <= `I2CMS_BYTE_RST;
    end else if (data_wr) begin
      tx_full <= 1'b1;
      tx_data <= data_wdata;
    end else if (evt.consume || flush_set) begin
      tx_full <= 1'b0;
    end
  end

  assign tx_data_empty_flag = !tx_full;
  assign tx_irq     = tx_data_empty_flag && tx_irq_enable && controller_enable;
  assign tx_dma_req = tx_data_empty_flag && tx_irq_enable && controller_enable;

  always_ff @(posedge clk) begin
    if (srst) begin
      nack_irq_flag <= 1'b0;
    end else if (evt.ack && ack_halt) begin
      nack_irq_flag <= 1'b1;
    end else if (start_set || stop_set) begin
      nack_irq_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ack_status <= 1'b0;
    end else if (evt.ack) begin
      ack_status <= ack_val;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_data_full_flag <= 1'b0;
      rx_data           <= `I2CMS_BYTE_RST;
    end else if (evt.rx) begin
      rx_data_full_flag <= 1'b1;
      rx_data           <= rx_byte;
    end else if (data_rd) begin
      rx_data_full_flag <= 1'b0;
    end
  end

  // A read of a full receive register releases the held bus
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_tgl <= 1'b0;
    end else if (data_rd && rx_data_full_flag && !evt.rx) begin
      rd_tgl <= !rd_tgl;
    end
  end

  // ---------------- Link domain ----------------

  always_ff @(posedge link_clk) begin
    link_rst_meta <= srst;
    link_rst      <= link_rst_meta;
  end

  assign ctl_src = '{enable: controller_enable, start: start_bit, stop: stop_bit,
                     full: tx_full, nak: nak_request};

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      ctl_meta <= '0;
      ctl_s    <= '0;
      rd_meta  <= 1'b0;
      rd_sync  <= 1'b0;
    end else begin
      ctl_meta <= ctl_src;
      ctl_s    <= ctl_meta;
      rd_meta  <= rd_tgl;
      rd_sync  <= rd_meta;
    end
  end

  // Idle bus reads high, so pins reset to released
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      scl_meta <= 1'b1;
      scl_s    <= 1'b1;
      sda_meta <= 1'b1;
      sda_s    <= 1'b1;
    end else begin
      scl_meta <= scl_in;
      scl_s    <= scl_meta;
      sda_meta <= sda_in;
      sda_s    <= sda_meta;
    end
  end

  // Slave holding SCL low freezes the quarter timer
  assign stretch = (phase == 2'h2) && !scl_oe && !scl_s;
  assign tick    = (qcnt == 8'h00) && !stretch;

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      qcnt <= QMAX;
    end else if (qcnt != 8'h00) begin
      qcnt <= qcnt - 8'h01;
    end else if (!stretch) begin
      qcnt <= QMAX;
    end
  end

  // A write byte needs a successor unless it is the last one
  assign stall = !rd_mode && !(addr_byte && dir_rd) && !ctl_s.full
                 && !ctl_s.start && !ctl_s.stop;

  // tx_data is stable while tx_full is set, so it is read here unsynchronised
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      state     <= i2cms_pkg::S_IDLE;
      phase     <= 2'h0;
      bitcnt    <= `I2CMS_BIT_FIRST;
      shreg     <= `I2CMS_BYTE_RST;
      rd_mode   <= 1'b0;
      addr_byte <= 1'b0;
      dir_rd    <= 1'b0;
      scl_oe    <= 1'b0;
      sda_oe    <= 1'b0;
      ack_val   <= 1'b0;
      ack_halt  <= 1'b0;
      rx_byte   <= `I2CMS_BYTE_RST;
      rd_seen   <= 1'b0;
      evt_tgl   <= '0;
    end else if (tick) begin
      phase <= phase + 2'h1;
      unique case (state)
        i2cms_pkg::S_IDLE: begin
          phase  <= 2'h0;
          scl_oe <= 1'b0;
          sda_oe <= 1'b0;
          if (ctl_s.enable && ctl_s.start && ctl_s.full) begin
            state <= i2cms_pkg::S_START;
          end
        end
        i2cms_pkg::S_START: begin
          unique case (phase)
            2'h0: sda_oe <= 1'b0;
            2'h1: sda_oe <= 1'b1;
            2'h2: scl_oe <= 1'b1;
            2'h3: begin
              shreg              <= tx_data;
              addr_byte          <= 1'b1;
              rd_mode            <= 1'b0;
              bitcnt             <= `I2CMS_BIT_FIRST;
              evt_tgl.start_done <= !evt_tgl.start_done;
              state              <= i2cms_pkg::S_BIT;
            end
          endcase
        end
        i2cms_pkg::S_BIT: begin
          unique case (phase)
            2'h0: sda_oe <= !rd_mode && !shreg[7];
            2'h1: scl_oe <= 1'b0;
            2'h2: shreg  <= {shreg[6:0], sda_s};
            2'h3: begin
              scl_oe <= 1'b1;
              if (!rd_mode && bitcnt == `I2CMS_BIT_FIRST) begin
                evt_tgl.consume <= !evt_tgl.consume;
              end
              if (bitcnt == `I2CMS_BIT_LAST) begin
                if (addr_byte) begin
                  dir_rd <= shreg[0];
                end
                state <= i2cms_pkg::S_ACK;
              end else begin
                bitcnt <= bitcnt - 3'h1;
              end
            end
          endcase
        end
        i2cms_pkg::S_ACK: begin
          unique case (phase)
            2'h0: begin
              if (stall) begin
                phase <= 2'h0;
              end else begin
                sda_oe <= rd_mode && !ctl_s.nak;
                if (rd_mode) begin
                  rx_byte    <= shreg;
                  evt_tgl.rx <= !evt_tgl.rx;
                end
              end
            end
            2'h1: scl_oe <= 1'b0;
            2'h2: begin
              if (!rd_mode) begin
                ack_val     <= !sda_s;
                ack_halt    <= sda_s && !ctl_s.start && !ctl_s.stop;
                evt_tgl.ack <= !evt_tgl.ack;
              end
            end
            2'h3: begin
              scl_oe    <= 1'b1;
              sda_oe    <= 1'b0;
              addr_byte <= 1'b0;
              bitcnt    <= `I2CMS_BIT_FIRST;
              if (rd_mode) begin
                state <= i2cms_pkg::S_HOLD;
              end else if (ack_halt) begin
                state <= i2cms_pkg::S_HALT;
              end else if (ctl_s.start) begin
                state <= i2cms_pkg::S_RESTART;
              end else if (ctl_s.stop) begin
                state <= i2cms_pkg::S_STOP;
              end else if (addr_byte && dir_rd) begin
                rd_mode <= 1'b1;
                state   <= i2cms_pkg::S_BIT;
              end else begin
                shreg <= tx_data;
                state <= i2cms_pkg::S_BIT;
              end
            end
          endcase
        end
        i2cms_pkg::S_HOLD: begin
          phase <= 2'h0;
          if (rd_sync != rd_seen) begin
            rd_seen <= rd_sync;
            if (ctl_s.start) begin
              state <= i2cms_pkg::S_RESTART;
            end else if (ctl_s.stop) begin
              state <= i2cms_pkg::S_STOP;
            end else begin
              state <= i2cms_pkg::S_BIT;
            end
          end
        end
        i2cms_pkg::S_HALT: begin
          phase <= 2'h0;
          if (ctl_s.start) begin
            state <= i2cms_pkg::S_RESTART;
          end else if (ctl_s.stop) begin
            state <= i2cms_pkg::S_STOP;
          end
        end
        i2cms_pkg::S_RESTART: begin
          unique case (phase)
            2'h0: begin
              sda_oe <= 1'b0;
              if (!ctl_s.full) begin
                phase <= 2'h0;
              end
            end
            2'h1: scl_oe <= 1'b0;
            2'h2: scl_oe <= 1'b0;
            2'h3: state  <= i2cms_pkg::S_START;
          endcase
        end
        i2cms_pkg::S_STOP: begin
          unique case (phase)
            2'h0: sda_oe <= 1'b1;
            2'h1: scl_oe <= 1'b0;
            2'h2: scl_oe <= 1'b0;
            2'h3: begin
              sda_oe            <= 1'b0;
              evt_tgl.stop_done <= !evt_tgl.stop_done;
              state             <= i2cms_pkg::S_IDLE;
            end
          endcase
        end
      endcase
    end
  end

  // ---------------- Checks ----------------

  chk_tx_empty_wr: assert property (@(posedge clk) disable iff (srst)
    data_wr |=> !tx_data_empty_flag) else $error("write did not clear transmit-empty");

  chk_dma_gate: assert property (@(posedge clk) disable iff (srst)
    tx_dma_req |-> tx_irq_enable && tx_data_empty_flag) else $error("ungated DMA request");

  chk_nack_set: assert property (@(posedge clk) disable iff (srst)
    evt.ack && ack_halt |=> nack_irq_flag) else $error("not-acknowledge flag not set");

  chk_nack_clear: assert property (@(posedge clk) disable iff (srst)
    nack_irq_flag && stop_set && !evt.ack |=> !nack_irq_flag) else $error("flag not cleared");

  chk_start_cond: assert property (@(posedge link_clk) disable iff (link_rst)
    $rose(sda_oe) && !scl_oe |-> state == i2cms_pkg::S_START) else $error("bad SDA fall");

  chk_stop_cond: assert property (@(posedge link_clk) disable iff (link_rst)
    $fell(sda_oe) && !scl_oe |-> $past(state) == i2cms_pkg::S_STOP) else $error("bad SDA rise");

  chk_ack_stall: assert property (@(posedge link_clk) disable iff (link_rst)
    state == i2cms_pkg::S_ACK && phase == 2'h0 && stall |=> phase == 2'h0)
    else $error("acknowledge not stalled");

  chk_no_stall_last: assert property (@(posedge link_clk) disable iff (link_rst)
    state == i2cms_pkg::S_ACK && phase == 2'h0 && tick && (ctl_s.start || ctl_s.stop)
    |=> phase == 2'h1) else $error("stalled before last acknowledge");

  chk_rx_hold: assert property (@(posedge link_clk) disable iff (link_rst)
    state == i2cms_pkg::S_HOLD && rd_sync == rd_seen |=> state == i2cms_pkg::S_HOLD)
    else $error("read hold released early");

  chk_stop_clear: assert property (@(posedge clk) disable iff (srst)
    evt.stop_done && !stop_set |=> !stop_bit) else $error("stop bit not cleared");

  chk_ack_status: assert property (@(posedge clk) disable iff (srst)
    evt.ack |=> ack_status == $past(ack_val)) else $error("acknowledge status wrong");

  chk_ack_sample: assert property (@(posedge link_clk) disable iff (link_rst)
    state == i2cms_pkg::S_ACK && phase == 2'h2 && tick && !rd_mode
    |=> ack_val == !$past(sda_s)) else $error("acknowledge sampled wrong");

  chk_rx_flag: assert property (@(posedge clk) disable iff (srst)
    evt.rx |=> rx_data_full_flag) else $error("receive-full not set");

endmodule

`default_nettype wire

// ==== i2cms_slave_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module i2cms_slave_model #(
  parameter int STRETCH_NS = 500
) (
  // Resolved bus levels
  input  wire logic       scl,
  input  wire logic       sda,
  // Behaviour controls
  input  wire logic       ack_en,
  input  wire logic       stretch_en,
  // Open-drain pulls, high pulls the line low
  output logic            sda_pull,
  output logic            scl_pull,
  // Observations
  output logic      [7:0] last_byte,
  output int              n_bytes,
  output int              n_starts,
  output int              n_stops
);
  logic [7:0] shreg;
  int         bit_cnt;
  logic       in_ack;

  initial begin
    sda_pull  = 1'b0;
    scl_pull  = 1'b0;
    last_byte = 8'h00;
    shreg     = 8'h00;
    n_bytes   = 0;
    n_starts  = 0;
    n_stops   = 0;
    bit_cnt   = 0;
    in_ack    = 1'b0;
  end

  // Start and repeated start both reframe
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      n_starts = n_starts + 1;
      bit_cnt  = 0;
      in_ack   = 1'b0;
    end
  end

  always @(posedge sda) begin
    if (scl === 1'b1) begin
      n_stops = n_stops + 1;
      bit_cnt = 0;
    end
  end

  // Restart and stop clocks land here too, reframing discards them
  always @(posedge scl) begin
    if (!in_ack && bit_cnt < 8) begin
      shreg   = {shreg[6:0], sda};
      bit_cnt = bit_cnt + 1;
    end
  end

  always @(negedge scl) begin
    if (in_ack) begin
      sda_pull <= 1'b0;
      in_ack  = 1'b0;
      bit_cnt = 0;
    end else if (bit_cnt == 8) begin
      last_byte = shreg;
      n_bytes   = n_bytes + 1;
      in_ack    = 1'b1;
      sda_pull <= ack_en;
      // Slow slave holds the clock low before its acknowledge
      if (stretch_en) begin
        scl_pull <= 1'b1;
        #(STRETCH_NS);
        scl_pull <= 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("ERROR %s expected %0h seen %0h", what, exp, got); end end

module tb_top;
  localparam int LIMIT = 60000;
  logic clk = 1'b0, link_clk = 1'b0, srst = 1'b1;
  logic controller_enable = 1'b0, tx_irq_enable = 1'b0, nak_request = 1'b0;
  logic start_set = 1'b0, stop_set = 1'b0, flush_set = 1'b0;
  logic data_wr = 1'b0, data_rd = 1'b0;
  logic [7:0] data_wdata = 8'h00, rx_data, last_byte;
  logic start_bit, stop_bit, tx_data_empty_flag, rx_data_full_flag, nack_irq_flag;
  logic ack_status, tx_irq, tx_dma_req, scl_oe, sda_oe, scl_pull, sda_pull;
  logic ack_en = 1'b1, stretch_en = 1'b0;
  int n_bytes, n_starts, n_stops, n_mismatch = 0, checks_done = 0, cyc = 0;
  int s0, p0, b0;
  logic [7:0] a, prev;
  wire logic scl = ~(scl_oe | scl_pull);
  wire logic sda = ~(sda_oe | sda_pull);

  always #2 clk = ~clk;
  initial begin
    #13;
    forever #40 link_clk = ~link_clk;
  end

  i2cms_sequencer #(.QTR_DIV(1)) i_dut (
    .clk(clk), .srst(srst), .link_clk(link_clk),
    .controller_enable(controller_enable), .tx_irq_enable(tx_irq_enable),
    .nak_request(nak_request), .start_set(start_set), .stop_set(stop_set),
    .flush_set(flush_set), .data_wr(data_wr), .data_wdata(data_wdata),
    .data_rd(data_rd), .rx_data(rx_data), .start_bit(start_bit), .stop_bit(stop_bit),
    .tx_data_empty_flag(tx_data_empty_flag), .rx_data_full_flag(rx_data_full_flag),
    .nack_irq_flag(nack_irq_flag), .ack_status(ack_status), .tx_irq(tx_irq),
    .tx_dma_req(tx_dma_req), .scl_in(scl), .scl_out(), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(), .sda_oe(sda_oe));

  i2cms_slave_model i_slave (
    .scl(scl), .sda(sda), .ack_en(ack_en), .stretch_en(stretch_en),
    .sda_pull(sda_pull), .scl_pull(scl_pull), .last_byte(last_byte),
    .n_bytes(n_bytes), .n_starts(n_starts), .n_stops(n_stops));

  function automatic logic [7:0] exp_addr(input logic [6:0] adr);
    return {adr, 1'b0};
  endfunction

  function automatic logic flag(input int sel);
    case (sel)
      0: return tx_data_empty_flag;
      1: return stop_bit;
      2: return nack_irq_flag;
      default: return start_bit;
    endcase
  endfunction

  task automatic end_of_test();
    $display("Totals: %0d checks, %0d mismatches", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic wr(input logic [7:0] b);
    @(posedge clk);
    data_wr    <= 1'b1;
    data_wdata <= b;
    @(posedge clk);
    data_wr    <= 1'b0;
    // Let the flags settle before the caller looks at them
    #1;
  endtask

  task automatic ctl(input logic st, input logic sp, input logic fl, input logic ie);
    @(posedge clk);
    start_set     <= st;
    stop_set      <= sp;
    flush_set     <= fl;
    tx_irq_enable <= ie;
    @(posedge clk);
    start_set <= 1'b0;
    stop_set  <= 1'b0;
    flush_set <= 1'b0;
    #1;
  endtask

  task automatic wait_for(input int sel, input logic val, input int lim, input string what);
    int n;
    n = 0;
    while (flag(sel) !== val && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(what, val, flag(sel))
  endtask

  task automatic snap();
    s0 = n_starts;
    p0 = n_stops;
    b0 = n_bytes;
    a  = exp_addr(7'($urandom));
  endtask

  // Write of nb data bytes; optional stall before the first acknowledge
  task automatic xfer(input int nb, input logic stall, input logic rs);
    snap();
    prev = a;
    wr(a);
    ctl(1'b1, 1'b0, 1'b0, 1'b1);
    wait_for(0, 1'b1, 400, "addr first bit");
    `CHK("start count", s0 + 1, n_starts)
    `CHK("tx irq", 1'b1, tx_irq)
    for (int k = 0; k < nb; k++) begin
      if (stall && k == 0) begin
        repeat (1500) @(posedge clk);
        #1;
        `CHK("scl held", 1'b0, scl)
        `CHK("no ack clock", b0 + 1, n_bytes)
      end
      wr(8'($urandom));
      wait_for(0, 1'b1, 1500, "data first bit");
      `CHK("byte on bus", prev, last_byte)
      prev = data_wdata;
    end
    if (rs) begin
      ctl(1'b1, 1'b0, 1'b0, 1'b1);
      a = exp_addr(7'($urandom));
      wr(a);
      wait_for(3, 1'b0, 3000, "restart done");
      `CHK("restart starts", s0 + 2, n_starts)
      `CHK("restart no stop", p0, n_stops)
      `CHK("byte before restart", prev, last_byte)
      prev = a;
    end
    ctl(1'b0, 1'b1, 1'b0, 1'b0);
    wait_for(1, 1'b0, 3000, "stop done");
    `CHK("stop count", p0 + 1, n_stops)
    `CHK("last byte", prev, last_byte)
    `CHK("ack status", 1'b1, ack_status)
    `CHK("nack quiet", 1'b0, nack_irq_flag)
    $display("Test xfer %0d bytes done", nb);
  endtask

  initial begin
    void'($urandom(58887));
    // Held long enough for the link domain to see reset too
    repeat (100) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("empty rst", 1'b1, tx_data_empty_flag)
    `CHK("dma rst", 1'b0, tx_dma_req)
    `CHK("sda rst", 1'b0, sda_oe)
    controller_enable <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK("dma gated", 1'b0, tx_dma_req)
    `CHK("empty no enable", 1'b1, tx_data_empty_flag)
    tx_irq_enable <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK("dma enabled", 1'b1, tx_dma_req)
    $display("Test reset done");
    snap();
    ctl(1'b1, 1'b0, 1'b0, 1'b0);
    repeat (400) @(posedge clk);
    #1;
    `CHK("no start empty", s0, n_starts)
    `CHK("sda idle", 1'b0, sda_oe)
    wr(a);
    ctl(1'b0, 1'b1, 1'b0, 1'b0);
    wait_for(1, 1'b0, 3000, "late probe");
    `CHK("late probe start", s0 + 1, n_starts)
    $display("Test start withheld done");
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      ack_en <= i[0];
      snap();
      wr(a);
      ctl(1'b1, 1'b1, 1'b0, 1'b0);
      wait_for(1, 1'b0, 3000, "probe stop");
      `CHK("probe byte", a, last_byte)
      `CHK("probe count", b0 + 1, n_bytes)
      `CHK("probe stops", p0 + 1, n_stops)
      `CHK("probe ack", i[0], ack_status)
      `CHK("probe nack", 1'b0, nack_irq_flag)
    end
    $display("Test probe done");
    @(posedge clk);
    ack_en     <= 1'b1;
    stretch_en <= 1'b1;
    xfer(1, 1'b1, 1'b0);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      stretch_en <= 1'($urandom);
      xfer(1 + $urandom % 3, 1'($urandom), 1'b0);
    end
    xfer(2, 1'b0, 1'b1);
    @(posedge clk);
    ack_en <= 1'b0;
    snap();
    wr(a);
    ctl(1'b1, 1'b0, 1'b0, 1'b1);
    wait_for(0, 1'b1, 400, "nack addr bit");
    wr(8'($urandom));
    wait_for(2, 1'b1, 1500, "nack flag");
    `CHK("nack ack status", 1'b0, ack_status)
    repeat (500) @(posedge clk);
    #1;
    `CHK("nack held", 1'b1, nack_irq_flag)
    `CHK("nack halted", p0, n_stops)
    `CHK("stale byte", 1'b0, tx_data_empty_flag)
    ctl(1'b0, 1'b1, 1'b1, 1'b0);
    @(posedge clk);
    #1;
    `CHK("nack cleared", 1'b0, nack_irq_flag)
    `CHK("flushed", 1'b1, tx_data_empty_flag)
    wait_for(1, 1'b0, 3000, "stop after nack");
    `CHK("nack stop", p0 + 1, n_stops)
    $display("Test nack done");
    end_of_test();
  end
endmodule

`default_nettype wire
